// ==== src/dsr_device.sv ====
// device end: serial command interpreter with read, config enable/disable
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module dsr_device #(
   parameter int RES_BITS   = 12,
   parameter int CHANNELS   = 8,
   parameter int NV_WC_CYC  = dsr_pkg::DSR_NV_WC_CYC
) (
   input  wire logic                          clk_sys,    // system clock
   input  wire logic                          rst_n,      // sync reset, active low
   dsr_if.device                              link,       // serial link
   input  wire logic [CHANNELS*RES_BITS-1:0]  chan_reg,   // pending channel register values
   input  wire logic [CHANNELS*RES_BITS-1:0]  chan_out,   // values at the outputs
   output logic                               cfg_bit,    // nonvolatile config bit
   output logic                               nv_busy     // nv write cycle active
);
   import dsr_pkg::*;
   initial begin
      if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12) $error("bad RES_BITS");
      if (CHANNELS != 4 && CHANNELS != 8) $error("bad CHANNELS");
      if (NV_WC_CYC < 1) $error("bad NV_WC_CYC");
   end

   // ****************************************
   // pin sampling
   // ****************************************
   logic [3:0] pins_s;
   dsr_sync #(.W(4)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({link.cs_n, link.sck, link.sdi, link.output_latch_pin}),
      .init    (4'h8),
      .q       (pins_s)
   );
   wire cs_n_s = pins_s[3];
   wire sck_s  = pins_s[2];
   wire sdi_s  = pins_s[1];
   wire lat_s  = pins_s[0];
   logic sck_prev_q;
   logic cs_prev_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         cs_prev_q  <= cs_n_s;
      end
   end
   wire sck_rise  = sck_s & ~sck_prev_q & ~cs_n_s;
   wire sck_fall  = ~sck_s & sck_prev_q & ~cs_n_s;
   wire cs_start  = cs_prev_q & ~cs_n_s;
   wire cs_end    = ~cs_prev_q & cs_n_s;

   // ****************************************
   // decode
   // ****************************************
   dsr_state_t  st_q;
   logic [4:0]  cnt_q;
   logic [6:0]  cmd_q;
   logic [15:0] shift_q;
   logic        sdo_q;
   logic        err_q;
   logic        prev_nv_q;
   logic        pend_nv_q;
   logic        pend_val_q;
   logic [31:0] wc_q;

   function automatic logic addr_ok(input logic [4:0] a);
      addr_ok = (a < 5'(CHANNELS)) || (a >= 5'h08 && a <= DSR_ADDR_LAST_VOL)
                || a == DSR_ADDR_CFG;
   endfunction
   function automatic logic is_vol(input logic [4:0] a);
      is_vol = (a <= DSR_ADDR_LAST_VOL);
   endfunction

   // judged on the first seven bits: the flag leaves before the eighth rise
   wire [4:0]  rx_addr  = cmd_q[6:2];                       // [R2]
   wire [1:0]  rx_code  = cmd_q[1:0];
   wire        is_read  = rx_code == DSR_CMD_READ;          // [R15]
   wire        is_cfg   = (rx_code == DSR_CMD_ENABLE || rx_code == DSR_CMD_DISABLE)
                          && rx_addr == DSR_ADDR_CFG;       // [R16] [R17]
   // hv qualifier is not looked at for reads [R10]
   wire        busy_blk = nv_busy && !(is_read && is_vol(rx_addr));     // [R6] [R19]
   wire        cmd_good = addr_ok(rx_addr) && (is_read || is_cfg) && !busy_blk
                          && !prev_nv_q;                    // [R8] [R20]
   wire [3:0]  ch_idx   = 4'(rx_addr);
   wire [RES_BITS-1:0] ch_val = lat_s ? chan_out[ch_idx*RES_BITS +: RES_BITS]
                                      : chan_reg[ch_idx*RES_BITS +: RES_BITS]; // [R9] [R11]
   wire [15:0] status_w = 16'(nv_busy) << DSR_STATUS_NVWA;  // [R7]
   wire [15:0] rd_word  = (rx_addr < 5'(CHANNELS)) ? 16'(ch_val)           // [R5]
                        : (rx_addr == DSR_ADDR_STATUS) ? status_w
                        : (rx_addr == DSR_ADDR_CFG) ? 16'(cfg_bit) : DSR_STATUS_RST;

   // ****************************************
   // serial state machine
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n || cs_start || cs_end) begin
         // select edges reset the interface; partial commands dropped [R21]
         st_q      <= DSR_CMD;
         cnt_q     <= 5'h00;
         cmd_q     <= 7'h00;
         shift_q   <= 16'h0000;
         sdo_q     <= 1'b0;
         err_q     <= 1'b0;
         prev_nv_q <= 1'b0;
         if (!rst_n) begin
            pend_nv_q  <= 1'b0;
            pend_val_q <= 1'b0;
         end else if (cs_end) begin
            pend_nv_q <= 1'b0;
         end
      end else if (sck_rise) begin                          // [R23]
         cnt_q <= (cnt_q == 5'(DSR_READ_BITS - 1)) ? 5'h00 : cnt_q + 5'h01;
         case (st_q)
            DSR_CMD: begin
               cmd_q <= {cmd_q[5:0], sdi_s};
               if (cnt_q == 5'(DSR_CMD_BITS - 1)) begin
                  err_q <= ~cmd_good;
                  if (!cmd_good) begin
                     st_q <= DSR_ERR;                       // [R8]
                  end else if (is_read) begin
                     st_q    <= DSR_DATA;                   // [R1]
                     shift_q <= rd_word;
                  end else begin
                     // complete config command: cycle launches on release [R18]
                     pend_nv_q  <= 1'b1;
                     pend_val_q <= (rx_code == DSR_CMD_ENABLE);
                     prev_nv_q  <= 1'b1;
                     cnt_q      <= 5'h00;
                  end
               end
            end
            DSR_DATA: begin
               if (cnt_q == 5'(DSR_READ_BITS - 1)) begin
                  st_q <= DSR_CMD;                          // [R14]
               end
            end
            DSR_ERR:  st_q <= DSR_ERR;
            default:  st_q <= DSR_ERR;
         endcase
      end else if (sck_fall) begin                          // [R23]
         if (st_q == DSR_ERR || err_q) begin
            sdo_q <= 1'b0;                                  // [R13] [R22]
         end else if (st_q == DSR_CMD && cnt_q == 5'h00 && prev_nv_q) begin
            sdo_q <= 1'b1;
         end else if (st_q == DSR_CMD && cnt_q == 5'(DSR_CMD_BITS - 1)) begin
            sdo_q <= cmd_good;                              // [R3] [R22]
         end else if (st_q == DSR_DATA && cnt_q >= 5'(DSR_CMD_BITS)) begin
            sdo_q   <= shift_q[15];                         // [R4]
            shift_q <= {shift_q[14:0], 1'b0};
         end else begin
            sdo_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // nonvolatile write cycle timer
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wc_q    <= 32'h0000_0000;
         nv_busy <= 1'b0;
         cfg_bit <= 1'b0;
      end else if (cs_end && pend_nv_q && !nv_busy) begin
         wc_q    <= 32'(NV_WC_CYC);                         // [R18]
         nv_busy <= 1'b1;
      end else if (nv_busy) begin
         wc_q <= wc_q - 32'h0000_0001;
         if (wc_q == 32'h0000_0001) begin
            nv_busy <= 1'b0;
            cfg_bit <= pend_val_q;
         end
      end
   end

   assign link.sdo    = sdo_q;
   assign link.sdo_oe = ~cs_n_s;
endmodule
`default_nettype wire

// ==== src/dsr_host.sv ====
// host end: issues read and config commands over the serial link
`timescale 1ns/10ps
`default_nettype none
module dsr_host #(
   parameter int DIV = dsr_pkg::DSR_HOST_DIV
) (
   input  wire logic        clk_sys, // system clock
   input  wire logic        rst_n,   // sync reset, active low
   dsr_if.host              link,    // serial link
   input  wire logic [1:0]  addr,    // register index
   input  wire logic [15:0] wdata,   // write data
   input  wire logic        wr,      // write strobe
   input  wire logic        rd,      // read strobe
   output logic      [15:0] rdata,   // read data, cycle after rd
   input  wire logic        lat_in,  // level for output latch pin
   input  wire logic        hvq_in   // level for hv qualifier
);
   import dsr_pkg::*;
   initial begin
      if (DIV < 2) $error("DIV must be at least 2");
   end
   logic        sdo_s;
   dsr_sync #(.W(1)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (link.sdo),
      .init    (1'b0),
      .q       (sdo_s)
   );
   logic [7:0]  div_q;
   logic        busy_q;
   logic        hold_q;
   logic        err_q;
   logic        sck_q;
   logic        cs_n_q;
   logic [5:0]  bit_q;
   logic [5:0]  nbits_q;
   logic [23:0] tx_q;
   logic [15:0] rx_q;
   wire  tick  = div_q == 8'(DIV - 1);
   wire  go    = wr && addr == 2'(DSR_HOST_REG_CMD) && wdata[DSR_CMD_GO] && !busy_q;
   // host sends address field then code first [R2]; 8 or 24 clocks [R1]
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_q   <= 8'h00;
         busy_q  <= 1'b0;
         hold_q  <= 1'b0;
         err_q   <= 1'b0;
         sck_q   <= 1'b0;
         cs_n_q  <= 1'b1;
         bit_q   <= 6'h00;
         nbits_q <= 6'h00;
         tx_q    <= 24'h000000;
         rx_q    <= 16'h0000;
      end else if (go) begin
         busy_q  <= 1'b1;
         hold_q  <= wdata[DSR_CMD_HOLD];
         cs_n_q  <= 1'b0;
         div_q   <= 8'h00;
         bit_q   <= 6'h00;
         nbits_q <= wdata[DSR_CMD_LONG] ? 6'(DSR_READ_BITS) : 6'(DSR_CMD_BITS);
         tx_q    <= {wdata[7:0], 16'h0000};
      end else if (busy_q) begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         if (tick) begin
            if (bit_q == nbits_q) begin
               busy_q <= 1'b0;
               cs_n_q <= ~hold_q;  // hold select for back-to-back reads [R14]
            end else if (!sck_q) begin
               sck_q <= 1'b1;      // device samples on rise [R23]
            end else begin
               // sdo taken late in the high phase: pin and sync delay exceed DIV
               if (bit_q == 6'(DSR_CMD_BITS - 1)) err_q <= ~sdo_s;
               else if (bit_q >= 6'(DSR_CMD_BITS)) rx_q <= {rx_q[14:0], sdo_s};
               sck_q <= 1'b0;
               tx_q  <= {tx_q[22:0], 1'b0};
               bit_q <= bit_q + 6'h01;
            end
         end
      end else if (wr && addr == 2'(DSR_HOST_REG_STAT)) begin
         cs_n_q <= 1'b1;           // release clears device error state [R8]
      end
   end
   // software compares successive channel reads itself
   always_ff @(posedge clk_sys) begin
      if (!rst_n) rdata <= 16'h0000;
      else if (rd) begin
         case (addr)
            2'(DSR_HOST_REG_STAT): rdata <= {13'h0000, ~cs_n_q, err_q, busy_q};
            2'(DSR_HOST_REG_DATA): rdata <= rx_q;
            default:               rdata <= 16'h0000;
         endcase
      end
   end
   assign link.cs_n                   = cs_n_q;
   assign link.sck                    = sck_q;
   assign link.sdi                    = tx_q[23];
   assign link.output_latch_pin       = lat_in;
   assign link.high_voltage_qualifier = hvq_in;
endmodule
`default_nettype wire

// ==== src/dsr_if.sv ====
// interface: serial link between host and device
`timescale 1ns/10ps
`default_nettype none
interface dsr_if;
   logic cs_n;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic output_latch_pin;
   logic high_voltage_qualifier;
   modport device (input cs_n, sck, sdi, output_latch_pin, high_voltage_qualifier,
                   output sdo, sdo_oe);
   modport host (output cs_n, sck, sdi, output_latch_pin, high_voltage_qualifier,
                 input sdo, sdo_oe);
endinterface
`default_nettype wire

// ==== src/dsr_pkg.sv ====
// package: constants and types shared by the serial command device and host ends
// Functional notes
// (R1) read is 24 clocks: 8 command, 16 data
// (R2) host sends address then command code first
// (R3) eighth clock outputs command error flag
// (R4) clocks nine to twenty-four shift read data
// (R5) read data right-justified, upper bits zero
// (R6) nv write busy: only volatile reads served
// (R7) status register shows nv write active flag
// (R8) bad address errors; chip select release resets
// (R9) latch pin high: read returns output value
// (R10) high voltage qualifier does not change reads
// (R11) latch fall mid-read updates output, data may tear
// (R12) host repeats channel reads until two agree; dsr_host does not repeat or compare reads
// (R13) after error flag low, output stays low
// (R14) back-to-back reads allowed within one select
// (R15) read command code is binary 11
// (R16) config enable is 8-bit, code 10
// (R17) config disable is 8-bit, code 01
// (R18) nv cycle starts only after complete command
// (R19) during nv cycle ignore non-volatile commands
// (R20) disallowed position forces error until release
// (R21) select release resets, partial commands dropped
// (R22) error flag 1 valid, 0 on error
// (R23) sample on rising, change on falling edge
package dsr_pkg;
   localparam int          DSR_ADDR_W        = 5;
   localparam int          DSR_DATA_W        = 16;
   localparam int          DSR_CMD_BITS      = 8;
   localparam int          DSR_READ_BITS     = 24;
   localparam logic [1:0]  DSR_CMD_READ      = 2'h3;
   localparam logic [1:0]  DSR_CMD_ENABLE    = 2'h2;
   localparam logic [1:0]  DSR_CMD_DISABLE   = 2'h1;
   localparam logic [1:0]  DSR_CMD_WRITE     = 2'h0;
   localparam logic [4:0]  DSR_ADDR_STATUS   = 5'h0A;
   localparam logic [4:0]  DSR_ADDR_LAST_VOL = 5'h0A;
   localparam logic [4:0]  DSR_ADDR_CFG      = 5'h0B;
   localparam int          DSR_STATUS_NVWA   = 6;
   localparam logic [15:0] DSR_STATUS_RST    = 16'h0000;
   localparam int          DSR_NV_WC_US      = 10;
   localparam int          DSR_CLK_MHZ       = 10;
   localparam int          DSR_NV_WC_CYC     = DSR_NV_WC_US * DSR_CLK_MHZ;
   localparam int          DSR_HOST_DIV      = 4;
   localparam int          DSR_HOST_REG_CMD  = 0;
   localparam int          DSR_HOST_REG_STAT = 1;
   localparam int          DSR_HOST_REG_DATA = 2;
   localparam int          DSR_CMD_GO        = 8;
   localparam int          DSR_CMD_LONG      = 9;
   localparam int          DSR_CMD_HOLD      = 10;
   typedef enum logic [1:0] {
      DSR_IDLE = 2'b00,
      DSR_CMD  = 2'b01,
      DSR_DATA = 2'b10,
      DSR_ERR  = 2'b11
   } dsr_state_t;
endpackage

// ==== src/dsr_sync.sv ====
// two-flop synchroniser for link pins
`timescale 1ns/10ps
`default_nettype none
module dsr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys, // system clock
   input  wire logic         rst_n,   // sync reset, active low
   input  wire logic [W-1:0] d,       // asynchronous input
   input  wire logic [W-1:0] init,    // value during reset
   output logic      [W-1:0] q        // synchronised output
);
   logic [W-1:0] s1_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_q <= init;
         q    <= init;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
endmodule
`default_nettype wire

// ==== tb/dsr_checker.sv ====
// checker: serial link timing and error flag behaviour
`timescale 1ns/10ps
`default_nettype none
module dsr_checker (
   input wire logic clk_sys, // system clock
   input wire logic rst_n,   // sync reset, active low
   input wire logic cs_n,    // select, active low
   input wire logic sck,     // link clock
   input wire logic sdi,     // host to device data
   input wire logic sdo,     // device to host data
   input wire logic sdo_oe   // device drive enable
);
   import dsr_pkg::*;
   // ****************
   // frame tracking
   // ****************
   logic       sck_q;
   logic       first_q;
   logic       err_q;
   logic [4:0] pos_q;
   logic [6:0] sh_q;
   logic [6:0] cmd_q;
   wire        rise  = sck & ~sck_q;
   wire        flag  = rise && pos_q == 5'h07;
   // config commands are one byte, reads three
   wire        wrap  = pos_q == 5'h17 || (flag && (sh_q[1] ^ sh_q[0]));
   wire        ch_rd = cmd_q[1:0] == DSR_CMD_READ && cmd_q[6:2] < 5'h08;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk_sys) begin
      sck_q <= sck;
      if (!rst_n || cs_n) begin
         pos_q   <= 5'h00;
         first_q <= 1'b1;
         err_q   <= 1'b0;
      end else if (rise) begin
         sh_q  <= {sh_q[5:0], sdi};
         pos_q <= wrap ? 5'h00 : pos_q + 5'h01;
         if (flag) cmd_q <= sh_q;
         if (flag && !sdo) err_q <= 1'b1;
         if (wrap) first_q <= 1'b0;
      end
   end
   // ****************
   // assertions
   // ****************
   sequence s_high;
      sck[*4] ##1 !sck;
   endsequence
   oe_idle_a: assert property (cs_n[*4] |-> !sdo_oe)
      else $error("sdo driven while deselected");
   sck_phase_a: assert property ($rose(sck) |-> s_high)
      else $error("clock high phase wrong");
   sdi_edge_a: assert property ($changed(sdi) |-> !sck)
      else $error("sdi moved while clock high");
   sdo_edge_a: assert property (!cs_n && $changed(sdo) |-> !sck)
      else $error("sdo moved while clock high");
   frame_len_a: assert property ($rose(cs_n) |-> pos_q[2:0] == 3'h0)
      else $error("select released mid byte");
   bad_addr_a: assert property (flag && sh_q[6:2] > DSR_ADDR_CFG |-> !sdo)
      else $error("bad address accepted");
   good_rd_a: assert property (flag && first_q && sh_q[1:0] == DSR_CMD_READ
      && sh_q[6:2] <= DSR_ADDR_STATUS |-> sdo) else $error("valid read refused");
   err_hold_a: assert property (err_q && !cs_n |-> !sdo)
      else $error("sdo high after error");
   upper_zero_a: assert property (rise && ch_rd && !err_q && pos_q >= 5'h08
      && pos_q <= 5'h0B |-> !sdo) else $error("unused data bit set");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// testbench: host and device ends joined over the serial link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dsr_pkg::*;
   localparam int RB = 12;
   logic            clk_sys = 1'b0;
   logic            rst_n   = 1'b0;
   logic [1:0]      addr    = 2'h0;
   logic [15:0]     wdata   = 16'h0000;
   logic            wr      = 1'b0;
   logic            rd      = 1'b0;
   logic            lat_in  = 1'b0;
   logic            hvq_in  = 1'b0;
   logic [15:0]     rdata;
   logic [8*RB-1:0] chan_reg;
   logic [8*RB-1:0] chan_out;
   logic            cfg_bit;
   logic            nv_busy;
   int              num_errors   = 0;
   int              total_checks = 0;
   dsr_if link();
   dsr_host u_dsr_host(.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lat_in(lat_in), .hvq_in(hvq_in));
   // long nv cycle so reads can land inside it
   dsr_device #(.RES_BITS(RB), .CHANNELS(8), .NV_WC_CYC(800)) u_dsr_device(
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .chan_reg(chan_reg),
      .chan_out(chan_out), .cfg_bit(cfg_bit), .nv_busy(nv_busy));
   dsr_checker u_dsr_checker(.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(link.cs_n),
      .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
   always #50 clk_sys = ~clk_sys;
   // ****************
   // helpers
   // ****************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [1:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // bits: 8 go, 9 three-byte read, 10 keep select
   task automatic send(input logic [4:0] a, input logic [1:0] c, input logic hold,
                       output logic [15:0] st);
      reg_wr(2'h0, {5'h00, hold, c == DSR_CMD_READ, 1'b1, a, c, 1'b0});
      for (int i = 0; i < 300; i++) begin
         reg_rd(2'h1, st);
         if (st[0] === 1'b0) return;
      end
      num_errors++;
      end_sim();
   endtask
   task automatic wait_nv(input logic lvl);
      for (int i = 0; i < 2000; i++) begin
         @(posedge clk_sys);
         if (nv_busy === lvl) return;
      end
      num_errors++;
      end_sim();
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_lat();
      logic [15:0] st, d, d2;
      logic [11:0] v;
      for (int m = 0; m < 4; m++) begin
         hvq_in <= m[0];
         lat_in <= m[1];
         v = m[1] ? chan_out[3*RB+:RB] : chan_reg[3*RB+:RB];
         send(5'h03, DSR_CMD_READ, 1'b0, st);
         chk(st & 16'h0002, 16'h0000);
         reg_rd(2'h2, d);
         chk(d, {4'h0, v});
         send(5'h03, DSR_CMD_READ, 1'b0, st);
         reg_rd(2'h2, d2);
         chk(d2, d);
      end
      $display("test latch done");
   endtask
   task automatic t_b2b();
      logic [15:0] st, d;
      lat_in <= 1'b0;
      send(5'h05, DSR_CMD_READ, 1'b1, st);
      chk(st & 16'h0006, 16'h0004);
      reg_rd(2'h2, d);
      chk(d, {4'h0, chan_reg[5*RB+:RB]});
      send(DSR_ADDR_STATUS, DSR_CMD_READ, 1'b1, st);
      reg_rd(2'h2, d);
      chk(d, DSR_STATUS_RST);
      reg_wr(2'h1, 16'h0000);
      $display("test back to back done");
   endtask
   task automatic t_cfg();
      logic [15:0] st, d;
      chk({15'h0, cfg_bit}, 16'h0000);
      send(DSR_ADDR_CFG, DSR_CMD_ENABLE, 1'b1, st);
      chk({14'h0, nv_busy, cfg_bit}, 16'h0000);
      reg_wr(2'h1, 16'h0000);
      wait_nv(1'b1);
      send(DSR_ADDR_STATUS, DSR_CMD_READ, 1'b0, st);
      reg_rd(2'h2, d);
      chk({15'h0, d[DSR_STATUS_NVWA]}, 16'h0001);
      send(DSR_ADDR_CFG, DSR_CMD_DISABLE, 1'b1, st);
      reg_wr(2'h1, 16'h0000);
      wait_nv(1'b0);
      chk({15'h0, cfg_bit}, 16'h0001);
      send(DSR_ADDR_CFG, DSR_CMD_DISABLE, 1'b1, st);
      reg_wr(2'h1, 16'h0000);
      wait_nv(1'b1);
      wait_nv(1'b0);
      chk({15'h0, cfg_bit}, 16'h0000);
      $display("test config done");
   endtask
   task automatic t_err();
      logic [15:0] st, d;
      send(5'h1F, DSR_CMD_READ, 1'b0, st);
      chk(st & 16'h0002, 16'h0002);
      reg_rd(2'h2, d);
      chk(d, 16'h0000);
      send(DSR_ADDR_CFG, DSR_CMD_ENABLE, 1'b1, st);
      send(DSR_ADDR_STATUS, DSR_CMD_READ, 1'b1, st);
      chk(st & 16'h0002, 16'h0002);
      reg_rd(2'h2, d);
      chk(d, 16'h0000);
      reg_wr(2'h1, 16'h0000);
      $display("test error done");
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         chan_reg[i*RB+:RB] = 12'hA50 + 12'(i);
         chan_out[i*RB+:RB] = 12'h3C0 + 12'(i);
      end
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_lat();
      t_b2b();
      t_cfg();
      t_err();
      end_sim();
   end
endmodule
`default_nettype wire
